// File: core/iicm_pin_setup.v
// Operation
// - Control resets zero; level bits ignore writes
// - Wake bit, once armed for three ticks, keeps address compare in halt
// - Wake mode suppresses stop interrupt
// - Non-interrupt wake clear blocks master start
// - Clock level bit follows line when enabled
// - Data level bit follows line when enabled
// - Speed bit selects normal or fast mode
// - Noise filter bit, fast mode only
// - Prescale bit halves system clock
// - Low width times driven clock low
// - Data hold is quarter low width
// - High width times driven clock high
// - Disabled controller drives pins low in output mode
// - Direction register resets ones, high bits fixed
// - Output type register resets zero
// - Lines only pulled low or released
// - Widths count operation clock periods
`timescale 1ns/1ns
`default_nettype none
`include "iicm_regs.vh"

module iicm_pin_setup (
    input wire clk,
    input wire nrst,
    input wire clk_en,
    // Register access port
    input wire [19:0] reg_addr,
    input wire reg_wr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    // From the main control and status logic
    input wire operation_enable,
    input wire start_request,
    input wire stop_irq_enable,
    input wire master_status_flag,
    input wire extension_code_flag,
    input wire address_match_flag,
    input wire start_detected_flag,
    input wire start_cond_seen,
    input wire stop_cond_seen,
    input wire stop_event,
    input wire ctrl_irq,
    input wire deep_halt,
    // From protocol engine: requested line levels and timing
    input wire eng_scl_low,
    input wire eng_sda_low,
    input wire eng_phase_start,
    // Bus pins as three signals each
    input wire bus_clock_pin_i,
    output reg bus_clock_pin_o,
    output reg bus_clock_pin_oe,
    input wire bus_data_pin_i,
    output reg bus_data_pin_o,
    output reg bus_data_pin_oe,
    // To protocol engine
    output reg scl_level_r,
    output reg sda_level_r,
    output reg op_tick_r,
    output reg scl_phase_done_r,
    output reg data_hold_done_r,
    output reg fast_mode_r,
    output reg filter_on_r,
    output reg addr_cmp_active_r,
    output reg stop_irq_r,
    output reg master_block_r,
    output reg start_allowed_r
);

////////////////////////////////////////////////////////////////////////////////
// Registers
reg [7:0] ctl2_r; // Stored control bits
reg [7:0] wl_r; // Low width count
reg [7:0] wh_r; // High width count
reg [7:0] pdir_r; // Port direction
reg [7:0] pom_r; // Port output type
reg scl_s1_r; // Clock line sync stage one
reg scl_s2_r; // Clock line sync stage two
reg sda_s1_r; // Data line sync stage one
reg sda_s2_r; // Data line sync stage two
reg scl_f_r; // Filtered clock level
reg sda_f_r; // Filtered data level
reg scl_p_r; // Clock level at previous tick
reg sda_p_r; // Data level at previous tick
reg div_r; // Prescale toggle
reg [8:0] cnt_r; // Phase counter
reg [8:0] cnt_nxt;
reg drv_low_r; // Previous driven clock state
reg [1:0] arm_r; // Wake arming counter
reg wake_prev_r; // Wake bit one cycle ago

wire wake = ctl2_r[`IICM_B_WAKE];
wire prs = ctl2_r[`IICM_B_PRS];

////////////////////////////////////////////////////////////////////////////////
// Address match function, used by reads and writes
function hit;
    input [19:0] a;
    input [19:0] ref_a;
    begin
        hit = (a == ref_a);
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Register writes
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        ctl2_r <= `IICM_RST_CTL2;
        wl_r <= `IICM_RST_WL;
        wh_r <= `IICM_RST_WH;
        pdir_r <= `IICM_RST_PDIR;
        pom_r <= `IICM_RST_POM;
    end else if (clk_en) begin
        if (reg_wr && hit(reg_addr, `IICM_ADDR_CTL2)) begin
            // Level bits are read-only, reserved bits stay zero
            ctl2_r <= reg_wdata & `IICM_CTL2_WMASK;
        end
        if (reg_wr && hit(reg_addr, `IICM_ADDR_WL)) begin
            wl_r <= reg_wdata;
        end
        if (reg_wr && hit(reg_addr, `IICM_ADDR_WH)) begin
            wh_r <= reg_wdata;
        end
        if (reg_wr && hit(reg_addr, `IICM_ADDR_PDIR)) begin
            // Upper bits held at one regardless of software
            pdir_r <= reg_wdata | `IICM_PDIR_FIXED;
        end
        if (reg_wr && hit(reg_addr, `IICM_ADDR_POM)) begin
            pom_r <= reg_wdata & `IICM_POM_MASK;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers; first stage feeds only the second
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        scl_s1_r <= 1'b1;
        scl_s2_r <= 1'b1;
        sda_s1_r <= 1'b1;
        sda_s2_r <= 1'b1;
    end else if (clk_en) begin
        scl_s1_r <= bus_clock_pin_i;
        scl_s2_r <= scl_s1_r;
        sda_s1_r <= bus_data_pin_i;
        sda_s2_r <= sda_s1_r;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Operation clock tick: every cycle, or every second cycle
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        div_r <= 1'b0;
        op_tick_r <= 1'b0;
    end else if (clk_en) begin
        div_r <= ~div_r;
        op_tick_r <= prs ? div_r : 1'b1;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Noise filter: a level change must persist two ticks
// Trades a tick of latency for glitch rejection
// Compares against the previous tick, not the status bit, so it cannot lock up
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        scl_f_r <= 1'b1;
        sda_f_r <= 1'b1;
        scl_p_r <= 1'b1;
        sda_p_r <= 1'b1;
    end else if (clk_en && op_tick_r) begin
        scl_p_r <= scl_s2_r;
        sda_p_r <= sda_s2_r;
        if (!filter_on_r || scl_s2_r == scl_p_r) begin
            scl_f_r <= scl_s2_r;
        end
        if (!filter_on_r || sda_s2_r == sda_p_r) begin
            sda_f_r <= sda_s2_r;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Level status bits, forced low while stopped
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        scl_level_r <= 1'b0;
        sda_level_r <= 1'b0;
    end else if (clk_en) begin
        if (!operation_enable) begin
            scl_level_r <= 1'b0;
            sda_level_r <= 1'b0;
        end else begin
            scl_level_r <= filter_on_r ? scl_f_r : scl_s2_r;
            sda_level_r <= filter_on_r ? sda_f_r : sda_s2_r;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Mode outputs; filter only acts in fast mode, timing unaffected
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        fast_mode_r <= 1'b0;
        filter_on_r <= 1'b0;
    end else if (clk_en) begin
        fast_mode_r <= ctl2_r[`IICM_B_SPEED];
        filter_on_r <= ctl2_r[`IICM_B_FILT] & ctl2_r[`IICM_B_SPEED];
    end
end

////////////////////////////////////////////////////////////////////////////////
// Phase counter: counts operation clock ticks of the driven phase
always @* begin
    cnt_nxt = cnt_r;
    if (eng_phase_start || drv_low_r != eng_scl_low) begin
        cnt_nxt = 9'h000;
    end else if (op_tick_r && cnt_r != 9'h1FF) begin
        cnt_nxt = cnt_r + 9'h001;
    end
end

always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        cnt_r <= 9'h000;
        drv_low_r <= 1'b0;
        scl_phase_done_r <= 1'b0;
        data_hold_done_r <= 1'b0;
    end else if (clk_en) begin
        cnt_r <= cnt_nxt;
        drv_low_r <= eng_scl_low;
        // Low phase ends at low width, high phase at high width
        scl_phase_done_r <= eng_scl_low ? (cnt_nxt >= {1'b0, wl_r})
                                        : (cnt_nxt >= {1'b0, wh_r});
        // Hold after falling edge is a quarter of low width
        data_hold_done_r <= eng_scl_low && (cnt_nxt >= {3'b000, wl_r[7:2]});
    end
end

////////////////////////////////////////////////////////////////////////////////
// Wakeup control and master blocking
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        arm_r <= 2'h0;
        wake_prev_r <= 1'b0;
        addr_cmp_active_r <= 1'b0;
        stop_irq_r <= 1'b0;
        master_block_r <= 1'b0;
        start_allowed_r <= 1'b0;
    end else if (clk_en) begin
        wake_prev_r <= wake;
        // Arming needs three operation ticks, software waits for it
        if (!wake) begin
            arm_r <= 2'h0;
        end else if (op_tick_r && arm_r != `IICM_WAKE_ARM_CYC) begin
            arm_r <= arm_r + 2'h1;
        end
        // Address compare runs in halt only while wake armed
        addr_cmp_active_r <= !deep_halt || (wake && arm_r == `IICM_WAKE_ARM_CYC);
        // No stop interrupt while waking is enabled
        stop_irq_r <= stop_event && stop_irq_enable && !wake;
        // Clearing wake bit other than by interrupt blocks master
        if (start_cond_seen || stop_cond_seen || !operation_enable) begin
            master_block_r <= 1'b0;
        end else if (wake_prev_r && !wake && !ctrl_irq) begin
            master_block_r <= 1'b1;
        end
        start_allowed_r <= operation_enable && !master_block_r && start_request;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Pin drivers: only pull low or release, wired-AND on the bus
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        bus_clock_pin_o <= 1'b0;
        bus_clock_pin_oe <= 1'b0;
        bus_data_pin_o <= 1'b0;
        bus_data_pin_oe <= 1'b0;
    end else if (clk_en) begin
        bus_clock_pin_o <= 1'b0;
        bus_data_pin_o <= 1'b0;
        // Disabled: fixed low whenever the port is in output mode
        bus_clock_pin_oe <= !pdir_r[0] && (!operation_enable || eng_scl_low);
        bus_data_pin_oe <= !pdir_r[1] && (!operation_enable || eng_sda_low);
    end
end

////////////////////////////////////////////////////////////////////////////////
// Register read mux
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        reg_rdata <= 8'h00;
    end else if (clk_en) begin
        if (hit(reg_addr, `IICM_ADDR_CTL2)) begin
            reg_rdata <= {ctl2_r[7:6], scl_level_r, sda_level_r, ctl2_r[3:0]};
        end else if (hit(reg_addr, `IICM_ADDR_WL)) begin
            reg_rdata <= wl_r;
        end else if (hit(reg_addr, `IICM_ADDR_WH)) begin
            reg_rdata <= wh_r;
        end else if (hit(reg_addr, `IICM_ADDR_PDIR)) begin
            reg_rdata <= pdir_r;
        end else if (hit(reg_addr, `IICM_ADDR_POM)) begin
            reg_rdata <= pom_r;
        end else begin
            reg_rdata <= 8'h00;
        end
    end
end

endmodule
`default_nettype wire

// File: include/iicm_regs.vh
`ifndef IICM_REGS_VH
`define IICM_REGS_VH
// Register addresses (20-bit address space)
`define IICM_ADDR_W 20
`define IICM_ADDR_POM 20'hF0051
`define IICM_ADDR_CTL2 20'hF0231
`define IICM_ADDR_PDIR 20'hFFF21
`define IICM_ADDR_WL 20'hF0232
`define IICM_ADDR_WH 20'hF0233
// Reset values
`define IICM_RST_CTL2 8'h00
`define IICM_RST_POM 8'h00
`define IICM_RST_PDIR 8'hFF
`define IICM_RST_WL 8'hFF
`define IICM_RST_WH 8'hFF
// Second control register fields
`define IICM_B_WAKE 7
`define IICM_B_CLD 5
`define IICM_B_DAD 4
`define IICM_B_SPEED 3
`define IICM_B_FILT 2
`define IICM_B_PRS 0
// Writable mask of the second control register
`define IICM_CTL2_WMASK 8'h8D
// Port direction bits forced to one
`define IICM_PDIR_FIXED 8'hF8
// Port output type bits that exist
`define IICM_POM_MASK 8'h07
// Wakeup arming delay in operation clock cycles
`define IICM_WAKE_ARM_CYC 2'h3
`endif

// File: dv/iicm_pin_setup_assertions.sv
`timescale 1ns/1ns
`default_nettype none
// Port-level checks of the pin setup block
module iicm_pin_setup_chk (
    input wire logic clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic [19:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic operation_enable,
    input wire logic stop_event,
    input wire logic deep_halt,
    input wire logic bus_clock_pin_i,
    input wire logic bus_data_pin_i,
    input wire logic bus_clock_pin_o,
    input wire logic bus_data_pin_o,
    input wire logic scl_level_r,
    input wire logic sda_level_r,
    input wire logic fast_mode_r,
    input wire logic filter_on_r,
    input wire logic addr_cmp_active_r,
    input wire logic stop_irq_r,
    input wire logic master_block_r
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////////////////////////////
    a_levels_off: assert property (clk_en && !operation_enable |=> !scl_level_r && !sda_level_r)
        else $error("line level shown while disabled");
    // Eight steady cycles cover sync stages plus filter
    a_clock_follow: assert property ((clk_en && operation_enable && $stable(bus_clock_pin_i))[*8]
        |-> scl_level_r == bus_clock_pin_i) else $error("clock level stale");
    a_data_follow: assert property ((clk_en && operation_enable && $stable(bus_data_pin_i))[*8]
        |-> sda_level_r == bus_data_pin_i) else $error("data level stale");
    a_pull_low_only: assert property (!bus_clock_pin_o && !bus_data_pin_o)
        else $error("pin driven high");
    a_speed_write: assert property (clk_en && reg_wr && reg_addr == 20'hF0231 && !operation_enable
        ##1 clk_en |=> fast_mode_r == $past(reg_wdata[3], 2)) else $error("speed select lost");
    a_filter_fast: assert property (filter_on_r |-> fast_mode_r)
        else $error("filter on outside fast mode");
    a_block_clear: assert property (clk_en && !operation_enable |=> !master_block_r)
        else $error("master block kept while disabled");
    a_compare_live: assert property (clk_en && !deep_halt |=> addr_cmp_active_r)
        else $error("address compare off while running");
    a_stop_cause: assert property (stop_irq_r |-> $past(stop_event))
        else $error("stop interrupt without stop");
    a_reserved_zero: assert property (clk_en && reg_addr == 20'hF0231
        |=> reg_rdata[6] == 1'b0 && reg_rdata[1] == 1'b0) else $error("reserved bit set");
endmodule
bind iicm_pin_setup iicm_pin_setup_chk chk_u (.*);
`default_nettype wire

// File: dv/iicm_bus_model.sv
`timescale 1ns/1ns
`default_nettype none
// Other bus parties: pull-ups and a second master's clock
module iicm_bus_model (
    input wire logic run,
    input wire logic dut_scl_oe,
    input wire logic dut_sda_oe,
    input wire logic ext_sda_low,
    output logic scl,
    output logic sda
);
    // Far clock toggles only inside frames, else released
    logic ext_scl_low = 1'b0;
    always #32 ext_scl_low = run ? ~ext_scl_low : 1'b0;
    // Wired-AND, pull-up gives the high level
    assign scl = ~(dut_scl_oe | ext_scl_low);
    assign sda = ~(dut_sda_oe | ext_sda_low);
endmodule
`default_nettype wire

// File: dv/iicm_pin_setup_tb.sv
`timescale 1ns/1ns
`default_nettype none
module iicm_pin_setup_tb;
    logic clk = 0, nrst = 0, clk_en = 1, reg_wr = 0, op_en = 0, st_req = 0, sie = 0;
    logic sseen = 0, pseen = 0, sev = 0, cirq = 0, halt = 0, esl = 0, esd = 0, eps = 0;
    logic run = 0, xsd = 0, scl, sda, c_oe, d_oe, s;
    logic [19:0] reg_addr = 0;
    logic [7:0] reg_wdata = 0, reg_rdata;
    logic sl, dl, tick, pdone, hdone, fast, filt, acmp, sirq, blk, salw;
    logic [19:0] ad [5] = '{20'hF0231, 20'hF0232, 20'hF0233, 20'hFFF21, 20'hF0051};
    logic [7:0] rv [5] = '{8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h00};
    int errors = 0, comparisons = 0, cyc = 0, n, h, r;
    always #4 clk = ~clk;
    ////////////////////////////////////////////////////////////////
    iicm_pin_setup dut_u (.clk(clk), .nrst(nrst), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .operation_enable(op_en), .start_request(st_req), .stop_irq_enable(sie),
        .master_status_flag(1'b0), .extension_code_flag(1'b0), .address_match_flag(1'b0),
        .start_detected_flag(1'b0), .start_cond_seen(sseen), .stop_cond_seen(pseen),
        .stop_event(sev), .ctrl_irq(cirq), .deep_halt(halt), .eng_scl_low(esl),
        .eng_sda_low(esd), .eng_phase_start(eps), .bus_clock_pin_i(scl), .bus_clock_pin_o(),
        .bus_clock_pin_oe(c_oe), .bus_data_pin_i(sda), .bus_data_pin_o(),
        .bus_data_pin_oe(d_oe), .scl_level_r(sl), .sda_level_r(dl), .op_tick_r(tick),
        .scl_phase_done_r(pdone), .data_hold_done_r(hdone), .fast_mode_r(fast),
        .filter_on_r(filt), .addr_cmp_active_r(acmp), .stop_irq_r(sirq),
        .master_block_r(blk), .start_allowed_r(salw));
    iicm_bus_model bus_u (.run(run), .dut_scl_oe(c_oe), .dut_sda_oe(d_oe),
        .ext_sda_low(xsd), .scl(scl), .sda(sda));
    ////////////////////////////////////////////////////////////////
    task give_verdict;
        if (errors == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // One-cycle write strobe, released before the next access
    task wr(input logic [19:0] a, input logic [7:0] d);
        @(posedge clk) {reg_addr, reg_wr, reg_wdata} <= {a, 1'b1, d};
        @(posedge clk) reg_wr <= 1'b0;
    endtask
    // Read data lands one cycle after the address
    task rd(input logic [19:0] a, input logic [7:0] e);
        @(posedge clk) reg_addr <= a;
        @(posedge clk);
        #1 chk(reg_rdata, e);
    endtask
    task wait_n(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            give_verdict;
        end
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        for (int i = 0; i < 5; i++) rd(ad[i], rv[i]);
        wr(20'hF0231, 8'hFF);
        rd(20'hF0231, 8'h8D);
        chk({fast, filt}, 8'h03);
        // Halved operation clock ticks every other cycle
        r = 0;
        repeat (8) @(posedge clk) r += tick;
        chk(r[7:0], 8'h04);
        wr(20'hFFF21, 8'h00);
        rd(20'hFFF21, 8'hF8);
        wr(20'hF0051, 8'hFF);
        rd(20'hF0051, 8'h07);
        chk({c_oe, d_oe}, 8'h03);
        wr(20'hF0232, 8'h08);
        rd(20'hF0232, 8'h08);
        wr(20'hF0233, 8'h08);
        rd(20'hF0233, 8'h08);
        wr(20'hF0231, 8'h00);
        @(posedge clk) op_en <= 1'b1;
        @(posedge clk) xsd <= 1'b1;
        wait_n(8);
        rd(20'hF0231, 8'h20);
        @(posedge clk) xsd <= 1'b0;
        wait_n(8);
        chk(dl, 8'h01);
        // Undivided operation clock ticks every cycle
        r = 0;
        repeat (8) @(posedge clk) r += tick;
        chk(r[7:0], 8'h08);
        // Far master clocks a frame; level must follow it
        run = 1'b1;
        r = 0;
        repeat (48) @(posedge clk) r += (sl == 1'b0);
        run = 1'b0;
        chk(r > 8 && r < 40, 8'h01);
        @(posedge clk) esl <= 1'b1;
        wait_n(8);
        chk({c_oe, sl}, 8'h02);
        @(posedge clk) eps <= 1'b1;
        @(posedge clk) eps <= 1'b0;
        #1;
        h = 0;
        for (n = 1; n < 40 && pdone !== 1'b1; n++) begin
            wait_n(1);
            if (hdone === 1'b1 && h == 0) h = n;
        end
        chk(n >= 8 && n <= 11, 8'h01);
        chk(h >= 2 && h <= 4, 8'h01);
        @(posedge clk) esl <= 1'b0;
        // Wake armed: compare survives halt, stop interrupt held back
        wr(20'hF0231, 8'h80);
        wait_n(3);
        @(posedge clk) {halt, sie} <= 2'b11;
        wait_n(8);
        chk(acmp, 8'h01);
        @(posedge clk) sev <= 1'b1;
        @(posedge clk) sev <= 1'b0;
        s = 0;
        repeat (3) @(posedge clk) s |= sirq;
        chk(s, 8'h00);
        wr(20'hF0231, 8'h00);
        wait_n(2);
        chk({acmp, blk}, 8'h01);
        @(posedge clk) pseen <= 1'b1;
        @(posedge clk) pseen <= 1'b0;
        wait_n(2);
        chk(blk, 8'h00);
        // Start is passed on once the block has lifted
        @(posedge clk) st_req <= 1'b1;
        wait_n(2);
        chk(salw, 8'h01);
        @(posedge clk) st_req <= 1'b0;
        @(posedge clk) sev <= 1'b1;
        @(posedge clk) sev <= 1'b0;
        s = 0;
        repeat (3) @(posedge clk) s |= sirq;
        chk(s, 8'h01);
        @(posedge clk) op_en <= 1'b0;
        wait_n(3);
        chk({sl, dl}, 8'h00);
        // Filter in fast mode, set while stopped, must still follow the line
        wr(20'hF0231, 8'h0C);
        @(posedge clk) {op_en, xsd} <= 2'b11;
        wait_n(10);
        chk({sl, dl}, 8'h02);
        @(posedge clk) xsd <= 1'b0;
        wait_n(10);
        chk({sl, dl}, 8'h03);
        give_verdict;
    end
endmodule
`default_nettype wire
